/* pkg/rcs_pkg.sv */
// Package holding the register map, function codes and carrier types of the run command selector.
package rcs_pkg;

	localparam int unsigned N_IN    = 8;
	localparam int unsigned N_OUT   = 7;
	localparam int unsigned FN_W    = 12;
	localparam int unsigned SEL_W   = 8;
	localparam int unsigned ADDR_W  = 8;

	// Byte addresses of the register words.
	localparam logic [7:0] OFS_RUN_SOURCE_SELECT     = 8'h00;
	localparam logic [7:0] OFS_KEYPAD_DIRECTION      = 8'h04;
	localparam logic [7:0] OFS_MAIN_SPEED_SOURCE     = 8'h08;
	localparam logic [7:0] OFS_OVERRIDE_RUN_SOURCE   = 8'h0C;
	localparam logic [7:0] OFS_OVERRIDE_SPEED_SOURCE = 8'h10;
	localparam logic [7:0] OFS_INPUT_POLARITY        = 8'h14;
	localparam logic [7:0] OFS_STATUS                = 8'h18;
	localparam logic [7:0] OFS_INPUT_FUNCTION_BASE   = 8'h20;
	localparam logic [7:0] OFS_OUTPUT_FUNCTION_BASE  = 8'h40;

	// Run source encodings, shared by the normal and override selectors, followed by the parameter speed source code.
	localparam logic [7:0] SRC_TERMINAL   = 8'h00;
	localparam logic [7:0] SRC_THREE_WIRE = 8'h01;
	localparam logic [7:0] SRC_KEYPAD     = 8'h02;
	localparam logic [7:0] SRC_FIELDBUS   = 8'h03;
	localparam logic [7:0] SRC_OPTION     = 8'h04;
	localparam logic [7:0] SPEED_PARAMETER = 8'h07;

	localparam logic [7:0] RST_RUN_SOURCE_SELECT   = SRC_KEYPAD;
	localparam logic [7:0] RST_KEYPAD_DIRECTION    = 8'h00;
	localparam logic [7:0] RST_MAIN_SPEED_SOURCE   = 8'h00;
	localparam logic [7:0] RST_OVERRIDE_RUN_SOURCE = SRC_TERMINAL;
	localparam logic [7:0] RST_OVERRIDE_SPEED      = 8'h00;
	localparam logic [7:0] RST_INPUT_POLARITY      = 8'h00;

	// Input terminal function codes (decimal codes held in BCD).
	localparam logic [11:0] FN_NONE           = 12'h000;
	localparam logic [11:0] FN_FORWARD        = 12'h001;
	localparam logic [11:0] FN_BACKWARD       = 12'h002;
	localparam logic [11:0] FN_THREE_WIRE_GO  = 12'h010;
	localparam logic [11:0] FN_THREE_WIRE_HLT = 12'h011;
	localparam logic [11:0] FN_THREE_WIRE_DIR = 12'h012;
	localparam logic [11:0] FN_OVERRIDE       = 12'h017;

	// Output terminal function codes.
	localparam logic [11:0] OFN_KEYPAD_SEL  = 12'h00B;
	localparam logic [11:0] RST_OUT_FN_0    = 12'h002;
	localparam logic [11:0] RST_OUT_FN_1    = 12'h001;
	localparam logic [11:0] RST_OUT_FN_6    = 12'h011;

	typedef struct packed {
		logic run;
		logic reverse;
	} rcs_cmd_t;

	typedef struct packed {
		logic forward_request;
		logic backward_request;
		logic three_wire_go;
		logic three_wire_halt;
		logic three_wire_dir;
		logic override_input;
	} rcs_term_fn_t;

endpackage : rcs_pkg

/* verilog/rcs_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module rcs_sync #(
	parameter int unsigned W = 8
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import rcs_pkg::*;

	logic [W-1:0] meta_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : rcs_sync
`default_nettype wire

/* verilog/rcs_func_map.sv */
// Maps terminal function assignments and terminal levels onto active input functions.
`timescale 1ns/100ps
`default_nettype none
module rcs_func_map #(
	parameter int unsigned N = 8
) (
	input  wire logic [N*12-1:0]     fn_flat,
	input  wire logic [N-1:0]        cond,
	input  wire logic [N-1:0]        raw,
	output rcs_pkg::rcs_term_fn_t    fn_on
);
	import rcs_pkg::*;

	// A function with no terminal assigned simply never matches, so it stays inactive.
	function automatic logic fn_active(input logic [11:0] code, input logic [N-1:0] lvl,
		input logic [N*12-1:0] fns);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (fns[i*12 +: 12] == code && lvl[i])
				hit = 1'b1;
		end
		return hit;
	endfunction : fn_active

	always_comb begin
		fn_on.forward_request  = fn_active(FN_FORWARD, cond, fn_flat);
		fn_on.backward_request = fn_active(FN_BACKWARD, cond, fn_flat);
		fn_on.three_wire_go    = fn_active(FN_THREE_WIRE_GO, cond, fn_flat);
		// The halt input is always sensed normally-closed, whatever its polarity setting.
		fn_on.three_wire_halt  = fn_active(FN_THREE_WIRE_HLT, ~raw, fn_flat);
		fn_on.three_wire_dir   = fn_active(FN_THREE_WIRE_DIR, cond, fn_flat);
		fn_on.override_input   = fn_active(FN_OVERRIDE, cond, fn_flat);
	end

endmodule : rcs_func_map
`default_nettype wire

/* verilog/rcs_selector.sv */
// Run command source selector: APB registers, terminal decoding and the registered run command.
`timescale 1ns/100ps
`default_nettype none
module rcs_selector #(
	parameter int unsigned N_TERM = rcs_pkg::N_IN,
	parameter int unsigned N_OTERM = rcs_pkg::N_OUT
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [rcs_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [N_TERM-1:0]           term_in,
	input  wire logic                        keypad_run_key,
	input  wire logic                        keypad_stop_key,
	input  wire logic                        fieldbus_run,
	input  wire logic                        fieldbus_reverse,
	input  wire logic                        option_run,
	input  wire logic                        option_reverse,
	input  wire logic                        freq_cmd_valid,
	input  wire logic                        host_screen_open,
	output rcs_pkg::rcs_cmd_t                run_cmd,
	output logic      [7:0]                  run_source_eff,
	output logic      [7:0]                  speed_source_eff,
	output logic                             keypad_selected,
	output logic      [N_OTERM-1:0]          out_terminal
);
	import rcs_pkg::*;

	logic [7:0]          run_source_select_r;
	logic [7:0]          keypad_direction_r;
	logic [7:0]          main_speed_source_r;
	logic [7:0]          override_run_source_r;
	logic [7:0]          override_speed_source_r;
	logic [N_TERM-1:0]   input_polarity_r;
	logic [11:0]         in_fn_r [N_TERM];
	logic [11:0]         out_fn_r [N_OTERM];
	logic [N_TERM*12-1:0] in_fn_flat;
	logic [N_TERM+1:0]   pins_sync;
	logic [N_TERM-1:0]   term_raw;
	logic [N_TERM-1:0]   term_cond;
	logic                kp_run_s;
	logic                kp_stop_s;
	logic                kp_run_d_r;
	logic                tw_go_d_r;
	rcs_term_fn_t        fn_on;
	logic [7:0]          src_nxt;
	logic [7:0]          spd_nxt;
	logic [7:0]          src_prev_r;
	logic                kp_latch_r;
	logic                tw_latch_r;
	logic                lockout_r;
	logic                src_change;
	rcs_cmd_t            req_nxt;
	logic                acc_first;
	logic                wr_en;
	logic [31:0]         rd_data;
	logic                rd_hit;

	// Word decode of the function tables, shared by the read and the write path.
	function automatic logic word_at(input logic [7:0] addr, input logic [7:0] base,
		input int unsigned idx);
		return addr == base + 8'(4 * idx);
	endfunction : word_at

	// Pins pass two flops; the keypad keys share the same synchroniser group.
	rcs_sync #(
		.W (N_TERM + 2)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({keypad_stop_key, keypad_run_key, term_in}),
		.sync_out (pins_sync)
	);

	assign term_raw  = pins_sync[N_TERM-1:0];
	assign kp_run_s  = pins_sync[N_TERM];
	assign kp_stop_s = pins_sync[N_TERM+1];
	assign term_cond = term_raw ^ input_polarity_r;

	always_comb begin
		for (int i = 0; i < N_TERM; i++)
			in_fn_flat[i*12 +: 12] = in_fn_r[i];
	end

	rcs_func_map #(
		.N (N_TERM)
	) u_map (
		.fn_flat (in_fn_flat),
		.cond    (term_cond),
		.raw     (term_raw),
		.fn_on   (fn_on)
	);

	// APB: one wait state, so every access completes on its second access cycle.
	assign acc_first = psel && penable && !pready;
	assign wr_en     = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc_first;
			pslverr <= acc_first && !rd_hit;
			if (acc_first && !pwrite)
				prdata <= rd_hit ? rd_data : 32'h0000_0000;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (paddr)
			OFS_RUN_SOURCE_SELECT:     rd_data[7:0] = run_source_select_r;
			OFS_KEYPAD_DIRECTION:      rd_data[7:0] = keypad_direction_r;
			OFS_MAIN_SPEED_SOURCE:     rd_data[7:0] = main_speed_source_r;
			OFS_OVERRIDE_RUN_SOURCE:   rd_data[7:0] = override_run_source_r;
			OFS_OVERRIDE_SPEED_SOURCE: rd_data[7:0] = override_speed_source_r;
			OFS_INPUT_POLARITY:        rd_data[N_TERM-1:0] = input_polarity_r;
			OFS_STATUS: begin
				rd_data[7:0]   = run_source_eff;
				rd_data[15:8]  = speed_source_eff;
				rd_data[16]    = run_cmd.run;
				rd_data[17]    = run_cmd.reverse;
				rd_data[18]    = keypad_selected;
				rd_data[19]    = lockout_r;
				rd_data[20]    = fn_on.override_input;
				rd_data[21]    = host_screen_open;
				// Terminal levels after polarity, as the run logic sees every input but the three-wire halt, which it reads from the raw level.
				rd_data[24 +: N_TERM] = term_cond;
			end
			default: begin
				rd_hit = 1'b0;
				for (int i = 0; i < N_TERM; i++) begin
					if (word_at(paddr, OFS_INPUT_FUNCTION_BASE, i)) begin
						rd_data[11:0] = in_fn_r[i];
						rd_hit        = 1'b1;
					end
				end
				for (int k = 0; k < N_OTERM; k++) begin
					if (word_at(paddr, OFS_OUTPUT_FUNCTION_BASE, k)) begin
						rd_data[11:0] = out_fn_r[k];
						rd_hit        = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_source_select_r     <= RST_RUN_SOURCE_SELECT;
			keypad_direction_r      <= RST_KEYPAD_DIRECTION;
			main_speed_source_r     <= RST_MAIN_SPEED_SOURCE;
			override_run_source_r   <= RST_OVERRIDE_RUN_SOURCE;
			override_speed_source_r <= RST_OVERRIDE_SPEED;
			input_polarity_r        <= RST_INPUT_POLARITY[N_TERM-1:0];
		end else if (wr_en) begin
			case (paddr)
				OFS_RUN_SOURCE_SELECT:     run_source_select_r     <= pwdata[7:0];
				OFS_KEYPAD_DIRECTION:      keypad_direction_r      <= pwdata[7:0];
				OFS_MAIN_SPEED_SOURCE:     main_speed_source_r     <= pwdata[7:0];
				OFS_OVERRIDE_RUN_SOURCE:   override_run_source_r   <= pwdata[7:0];
				OFS_OVERRIDE_SPEED_SOURCE: override_speed_source_r <= pwdata[7:0];
				OFS_INPUT_POLARITY:        input_polarity_r        <= pwdata[N_TERM-1:0];
				default: ;
			endcase
		end
	end

	// Terminal function tables; forward and backward start on terminals 0 and 1.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < N_TERM; i++)
				in_fn_r[i] <= FN_NONE;
			in_fn_r[0] <= FN_FORWARD;
			in_fn_r[1] <= FN_BACKWARD;
		end else if (wr_en) begin
			for (int i = 0; i < N_TERM; i++) begin
				if (word_at(paddr, OFS_INPUT_FUNCTION_BASE, i))
					in_fn_r[i] <= pwdata[11:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < N_OTERM; k++)
				out_fn_r[k] <= FN_NONE;
			out_fn_r[0] <= RST_OUT_FN_0;
			out_fn_r[1] <= RST_OUT_FN_1;
			if (N_OTERM > 6)
				out_fn_r[6] <= RST_OUT_FN_6;
		end else if (wr_en) begin
			for (int k = 0; k < N_OTERM; k++) begin
				if (word_at(paddr, OFS_OUTPUT_FUNCTION_BASE, k))
					out_fn_r[k] <= pwdata[11:0];
			end
		end
	end

	// The host screen wins over the override input; the stored settings are never
	// overwritten, so closing the screen brings the prior values straight back.
	always_comb begin
		if (host_screen_open) begin
			src_nxt = SRC_FIELDBUS;
			spd_nxt = SPEED_PARAMETER;
		end else if (fn_on.override_input) begin
			src_nxt = override_run_source_r;
			spd_nxt = override_speed_source_r;
		end else begin
			src_nxt = run_source_select_r;
			spd_nxt = main_speed_source_r;
		end
	end

	// Keypad latch: run key edge sets, stop key clears; it only matters in keypad mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kp_run_d_r <= 1'b0;
			kp_latch_r <= 1'b0;
		end else begin
			kp_run_d_r <= kp_run_s;
			if (kp_stop_s || src_nxt != SRC_KEYPAD)
				kp_latch_r <= 1'b0;
			else if (kp_run_s && !kp_run_d_r)
				kp_latch_r <= 1'b1;
		end
	end

	// Three-wire latch: go edge starts only with halt on; halt off always stops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tw_go_d_r  <= 1'b0;
			tw_latch_r <= 1'b0;
		end else begin
			tw_go_d_r <= fn_on.three_wire_go;
			if (!fn_on.three_wire_halt || src_nxt != SRC_THREE_WIRE)
				tw_latch_r <= 1'b0;
			else if (fn_on.three_wire_go && !tw_go_d_r)
				tw_latch_r <= 1'b1;
		end
	end

	always_comb begin
		req_nxt = '0;
		case (src_nxt)
			SRC_TERMINAL: begin
				req_nxt.run     = fn_on.forward_request ^ fn_on.backward_request;
				req_nxt.reverse = fn_on.backward_request && !fn_on.forward_request;
			end
			SRC_THREE_WIRE: begin
				req_nxt.run     = tw_latch_r;
				req_nxt.reverse = fn_on.three_wire_dir;
			end
			SRC_KEYPAD: begin
				req_nxt.run     = kp_latch_r;
				req_nxt.reverse = keypad_direction_r == 8'h01;
			end
			SRC_FIELDBUS: begin
				req_nxt.run     = fieldbus_run;
				req_nxt.reverse = fieldbus_reverse;
			end
			SRC_OPTION: begin
				req_nxt.run     = option_run;
				req_nxt.reverse = option_reverse;
			end
			default: req_nxt = '0;
		endcase
	end

	// A source change is judged against the source registered one edge ago.
	assign src_change = src_nxt != src_prev_r;

	// A run-source switch while running, or onto a source whose request is already
	// up, latches a stop until that request is dropped: a command held across the
	// switch must never restart the drive by itself.
	// Speed-source changes are not looked at here, so they never stop the drive.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev_r <= RST_RUN_SOURCE_SELECT;
			lockout_r  <= 1'b0;
		end else begin
			src_prev_r <= src_nxt;
			if (src_change && (run_cmd.run || req_nxt.run))
				lockout_r <= 1'b1;
			else if (!req_nxt.run)
				lockout_r <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_cmd          <= '0;
			run_source_eff   <= RST_RUN_SOURCE_SELECT;
			speed_source_eff <= RST_MAIN_SPEED_SOURCE;
			keypad_selected  <= 1'b0;
		end else begin
			run_cmd.run      <= req_nxt.run && freq_cmd_valid && !lockout_r &&
				!src_change;
			// Direction follows the request even while stopped; only run is gated.
			run_cmd.reverse  <= req_nxt.reverse;
			run_source_eff   <= src_nxt;
			speed_source_eff <= spd_nxt;
			keypad_selected  <= src_nxt == SRC_KEYPAD;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_terminal <= '0;
		end else begin
			for (int k = 0; k < N_OTERM; k++)
				out_terminal[k] <= out_fn_r[k] == OFN_KEYPAD_SEL && src_nxt == SRC_KEYPAD;
		end
	end

endmodule : rcs_selector
`default_nettype wire

/* tb/rcs_partner.sv */
// Far-side model: input terminal contacts and momentary keypad keys.
`timescale 1ns/100ps
`default_nettype none
module rcs_partner (
	input  wire logic       pclk,
	input  wire logic [7:0] contact,
	input  wire logic       press_run,
	input  wire logic       press_stop,
	output logic      [7:0] term_in,
	output logic            keypad_run_key,
	output logic            keypad_stop_key
);
	logic [2:0] run_cnt;
	logic [2:0] stop_cnt;
	// A press is held four cycles, as a real key bounces far longer than the synchroniser needs.
	initial begin
		{run_cnt, stop_cnt, term_in, keypad_run_key, keypad_stop_key} = '0;
	end
	always @(posedge pclk) begin
		term_in         <= contact;
		run_cnt         <= press_run ? 3'h4 : run_cnt - (run_cnt != 3'h0);
		stop_cnt        <= press_stop ? 3'h4 : stop_cnt - (stop_cnt != 3'h0);
		keypad_run_key  <= run_cnt != 3'h0;
		keypad_stop_key <= stop_cnt != 3'h0;
	end
endmodule : rcs_partner
`default_nettype wire

/* tb/rcs_selector_props.sv */
// Concurrent checks on the run command selector ports.
`timescale 1ns/100ps
`default_nettype none
module rcs_selector_props #(
	parameter int unsigned N_OTERM = rcs_pkg::N_OUT
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               freq_cmd_valid,
	input wire logic               host_screen_open,
	input wire rcs_pkg::rcs_cmd_t  run_cmd,
	input wire logic [7:0]         run_source_eff,
	input wire logic [7:0]         speed_source_eff,
	input wire logic               keypad_selected,
	input wire logic [N_OTERM-1:0] out_terminal
);
	import rcs_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_screen_held;
		host_screen_open ##1 host_screen_open;
	endsequence
	sequence s_keypad_held;
		run_source_eff == SRC_KEYPAD ##1 run_source_eff == SRC_KEYPAD;
	endsequence
	a_reset_stop: assert property ($past(presetn) == 1'b0 |-> !run_cmd.run && run_source_eff == SRC_KEYPAD)
		else $error("state after reset is not a keypad stop");
	a_freq_gate: assert property (run_cmd.run |-> $past(freq_cmd_valid))
		else $error("run without a frequency command");
	a_screen_forces: assert property (s_screen_held |-> run_source_eff == SRC_FIELDBUS && speed_source_eff == SPEED_PARAMETER)
		else $error("host screen did not force both sources");
	a_keypad_flag: assert property (s_keypad_held |-> keypad_selected)
		else $error("keypad flag low with keypad source");
	a_source_lock: assert property ($changed(run_source_eff) |-> !run_cmd.run)
		else $error("run kept across a source change");
	a_bad_source: assert property (run_source_eff > SRC_OPTION |-> !run_cmd.run)
		else $error("run from an undefined source");
	a_out_keypad: assert property (out_terminal != '0 |-> keypad_selected || $past(keypad_selected))
		else $error("keypad output without keypad source");
	a_error_ready: assert property (pslverr |-> pready ##1 !pready)
		else $error("error response not a single ready pulse");
endmodule : rcs_selector_props
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the run command selector.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import rcs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, keypad_selected;
	logic        press_run, press_stop, fb_run, fb_rev, op_run, op_rev, freq_ok, screen;
	logic        keypad_run_key, keypad_stop_key;
	logic [7:0]  paddr, contact, term_in, run_src, spd_src;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [6:0]  out_term;
	logic [1:0]  e;
	rcs_cmd_t    run_cmd;
	int          bad_count, n_checks;
	logic [7:0]  ra [10] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h20, 8'h24, 8'h40, 8'h44, 8'h58, 8'h1C};
	logic [31:0] rv [10] = '{32'h2, 32'h0, 32'h0, 32'h0, 32'h1, 32'h2, 32'h2, 32'h1, 32'h11, 32'h0};

	rcs_partner PEER (.pclk(pclk), .contact(contact), .press_run(press_run),
		.press_stop(press_stop), .term_in(term_in), .keypad_run_key(keypad_run_key),
		.keypad_stop_key(keypad_stop_key));
	rcs_selector DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .term_in(term_in), .keypad_run_key(keypad_run_key),
		.keypad_stop_key(keypad_stop_key), .fieldbus_run(fb_run), .fieldbus_reverse(fb_rev),
		.option_run(op_run), .option_reverse(op_rev), .freq_cmd_valid(freq_ok),
		.host_screen_open(screen), .run_cmd(run_cmd), .run_source_eff(run_src),
		.speed_source_eff(spd_src), .keypad_selected(keypad_selected), .out_terminal(out_term));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Forward and backward together cancel, so only an exclusive request runs.
	function automatic logic [1:0] term_exp(input logic f, input logic b);
		return (f ^ b) ? {1'b1, b} : 2'b00;
	endfunction : term_exp

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : check

	// Direction is only meaningful while running, so it is masked when stopped.
	task automatic cmd_is(input logic r, input logic v, input string what);
		check({30'h0, run_cmd.run, run_cmd.run & run_cmd.reverse}, {30'h0, r, r & v}, what);
	endtask : cmd_is

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask : wt

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	initial begin
		wt(5000);
		bad_count++;
		give_verdict();
	end

	initial begin
		{psel, penable, pwrite, press_run, press_stop, fb_run, fb_rev, op_run, op_rev, screen} = '0;
		{paddr, pwdata, contact, presetn} = '0;
		freq_ok = 1'b1;
		seed = 32'h142FD118;
		wt(2);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, ra[i], 32'h0);
			check({31'h0, er}, {31'h0, ra[i] == 8'h1C}, "slave error");
			check(rd, rv[i], "reset value");
		end
		apb(1'b1, OFS_KEYPAD_DIRECTION, 32'h1);
		apb(1'b1, OFS_OUTPUT_FUNCTION_BASE, {20'h0, OFN_KEYPAD_SEL});
		press_run <= 1'b1;
		@(posedge pclk);
		press_run <= 1'b0;
		wt(8);
		cmd_is(1'b1, 1'b1, "keypad reverse run");
		check({30'h0, keypad_selected, out_term[0]}, 32'h3, "keypad output");
		freq_ok <= 1'b0;
		wt(2);
		cmd_is(1'b0, 1'b0, "no frequency");
		freq_ok <= 1'b1;
		press_stop <= 1'b1;
		@(posedge pclk);
		press_stop <= 1'b0;
		wt(8);
		cmd_is(1'b0, 1'b0, "keypad stop");
		apb(1'b1, OFS_RUN_SOURCE_SELECT, 32'h0);
		for (int i = 0; i < 4; i++) begin
			contact <= {6'h0, i[1:0]};
			wt(5);
			e = term_exp(i[0], i[1]);
			cmd_is(e[1], e[0], "terminal pair");
		end
		contact <= 8'h00;
		apb(1'b1, OFS_INPUT_POLARITY, 32'h1);
		wt(4);
		cmd_is(1'b1, 1'b0, "closed sensing");
		apb(1'b1, OFS_INPUT_POLARITY, 32'h0);
		apb(1'b1, OFS_INPUT_FUNCTION_BASE, {20'h0, FN_NONE});
		apb(1'b1, OFS_INPUT_FUNCTION_BASE + 8'h08, {20'h0, FN_FORWARD});
		contact <= 8'h05;
		wt(5);
		cmd_is(1'b1, 1'b0, "moved forward terminal");
		contact <= 8'h01;
		wt(5);
		cmd_is(1'b0, 1'b0, "unassigned terminal");
		apb(1'b1, OFS_INPUT_FUNCTION_BASE + 8'h0C, {20'h0, FN_OVERRIDE});
		apb(1'b1, OFS_OVERRIDE_RUN_SOURCE, {24'h0, SRC_KEYPAD});
		apb(1'b1, OFS_OVERRIDE_SPEED_SOURCE, 32'h5);
		contact <= 8'h04;
		wt(5);
		cmd_is(1'b1, 1'b0, "running before override");
		contact <= 8'h0C;
		wt(5);
		cmd_is(1'b0, 1'b0, "override stop");
		check({24'h0, run_src}, {24'h0, SRC_KEYPAD}, "override run source");
		check({31'h0, keypad_selected}, 32'h1, "override keypad flag");
		check({24'h0, spd_src}, 32'h5, "override speed source");
		contact <= 8'h04;
		wt(5);
		cmd_is(1'b0, 1'b0, "locked out");
		contact <= 8'h00;
		wt(5);
		contact <= 8'h04;
		wt(5);
		cmd_is(1'b1, 1'b0, "restart after removal");
		screen <= 1'b1;
		wt(3);
		check({16'h0, run_src, spd_src}, {16'h0, SRC_FIELDBUS, SPEED_PARAMETER}, "screen");
		screen <= 1'b0;
		contact <= 8'h00;
		wt(3);
		check({16'h0, run_src, spd_src}, 32'h0, "screen restore");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			{fb_run, op_run} <= 2'b00;
			wt(2);
			apb(1'b1, OFS_RUN_SOURCE_SELECT, {24'h0, seed[0] ? SRC_OPTION : SRC_FIELDBUS});
			{fb_run, fb_rev, op_run, op_rev} <= seed[4:1];
			wt(3);
			cmd_is(seed[0] ? seed[2] : seed[4], seed[0] ? seed[1] : seed[3], "channel");
		end
		{fb_run, op_run} <= 2'b00;
		apb(1'b1, OFS_RUN_SOURCE_SELECT, {24'h0, SRC_THREE_WIRE});
		apb(1'b1, OFS_INPUT_FUNCTION_BASE + 8'h10, {20'h0, FN_THREE_WIRE_GO});
		apb(1'b1, OFS_INPUT_FUNCTION_BASE + 8'h14, {20'h0, FN_THREE_WIRE_HLT});
		apb(1'b1, OFS_INPUT_FUNCTION_BASE + 8'h18, {20'h0, FN_THREE_WIRE_DIR});
		contact <= 8'h40;
		wt(6);
		cmd_is(1'b0, 1'b0, "no start edge");
		contact <= 8'h50;
		wt(6);
		cmd_is(1'b1, 1'b1, "three wire start");
		contact <= 8'h40;
		wt(6);
		cmd_is(1'b1, 1'b1, "three wire held");
		contact <= 8'h60;
		wt(6);
		cmd_is(1'b0, 1'b0, "three wire halt");
		apb(1'b1, OFS_RUN_SOURCE_SELECT, 32'h5);
		fb_run <= 1'b1;
		wt(3);
		cmd_is(1'b0, 1'b0, "undefined source");
		give_verdict();
	end
endmodule : testbench

bind rcs_selector rcs_selector_props #(.N_OTERM(N_OTERM)) u_props (.pclk(pclk),
	.presetn(presetn), .pready(pready), .pslverr(pslverr), .freq_cmd_valid(freq_cmd_valid),
	.host_screen_open(host_screen_open), .run_cmd(run_cmd), .run_source_eff(run_source_eff),
	.speed_source_eff(speed_source_eff), .keypad_selected(keypad_selected),
	.out_terminal(out_terminal));
`default_nettype wire
